// [design/dpr_pkg.sv]
// Constants shared by the dual-port synchronous RAM model.
// Assumes the port pins come from logic outside the clk_sys domain.
// Functional notes
// - Selected port, write_n high at clock rise: read addressed word out.
// - Selected port, write_n low at clock rise: store input word.
// - Select gates the port clock; deselected edges have no effect.
// - Select high means standby; no access of any kind.
// - Both ports identical and independent, sharing only the array.
// - Clock low is precharge; accesses start only at rising edge.
// - Output drives only when clock high, selected and enabled.
// - During write with driver enabled, written word appears on output.
// - During read, stored addressed word appears on output when enabled.
// - Built from word count, bits per word, mux factor 2 to 32.
// - Words 2 to 256 times mux in mux steps; width 1 to 256/mux.
package dpr_pkg;
    localparam int DPR_YMUX = 4;
    localparam int DPR_WORDS = 256;
    localparam int DPR_BPW = 16;
    // range check of the build choice
    localparam bit DPR_MUX_OK = (DPR_YMUX == 2) || (DPR_YMUX == 4)
        || (DPR_YMUX == 8) || (DPR_YMUX == 16) || (DPR_YMUX == 32);
    localparam bit DPR_SIZE_OK = DPR_MUX_OK
        && (DPR_WORDS >= 2 * DPR_YMUX) && (DPR_WORDS <= 256 * DPR_YMUX)
        && (DPR_WORDS % DPR_YMUX == 0)
        && (DPR_BPW >= 1) && (DPR_BPW <= 256 / DPR_YMUX);
    localparam int DPR_AW = $clog2(DPR_WORDS);
    localparam int DPR_PW = 4 + DPR_AW + DPR_BPW;
    localparam int DPR_NPORT = 2;
    localparam int DPR_SYNC = 3;
    // Field positions in a bundled port sample
    localparam int DPR_F_DATA = 0;
    localparam int DPR_F_ADDR = DPR_BPW;
    localparam int DPR_F_OEN = DPR_BPW + DPR_AW;
    localparam int DPR_F_WRN = DPR_F_OEN + 1;
    localparam int DPR_F_SELN = DPR_F_OEN + 2;
    localparam int DPR_F_CLK = DPR_F_OEN + 3;
    localparam logic [DPR_BPW-1:0] DPR_DATA_RESET = '0;
endpackage

// [design/dpr_dual_port_ram.sv]
// Dual-port synchronous RAM modelled on clk_sys.
// Port clocks and controls are pins, oversampled through three flops.
// Output buses are split into data and output enable; the pad resolves Z.
`timescale 1ns/1ps
`default_nettype none
module dpr_dual_port_ram
    import dpr_pkg::*;
(
    input wire logic clk_sys,                           // System clock
    input wire logic reset_n,                           // Async reset
    input wire logic port_a_clock,                      // Port A clock pin
    input wire logic port_a_select_n,                   // Port A select
    input wire logic port_a_write_n,                    // Port A write
    input wire logic port_a_out_enable_n,               // Port A drive en
    input wire logic [DPR_AW-1:0] port_a_addr,          // Port A address
    input wire logic [DPR_BPW-1:0] port_a_write_data,   // Port A data in
    output logic [DPR_BPW-1:0] port_a_read_data,        // Port A data out
    output logic port_a_read_data_oe,                   // Port A driving
    input wire logic port_b_clock,                      // Port B clock pin
    input wire logic port_b_select_n,                   // Port B select
    input wire logic port_b_write_n,                    // Port B write
    input wire logic port_b_out_enable_n,               // Port B drive en
    input wire logic [DPR_AW-1:0] port_b_addr,          // Port B address
    input wire logic [DPR_BPW-1:0] port_b_write_data,   // Port B data in
    output logic [DPR_BPW-1:0] port_b_read_data,        // Port B data out
    output logic port_b_read_data_oe                    // Port B driving
);
    logic [DPR_PW-1:0] pinSample [DPR_NPORT];
    logic [DPR_PW-1:0] syncStage [DPR_NPORT][DPR_SYNC];
    logic [DPR_PW-1:0] next_syncStage [DPR_NPORT][DPR_SYNC];
    logic [DPR_PW-1:0] level [DPR_NPORT];
    logic [DPR_PW-1:0] next_level [DPR_NPORT];
    logic [DPR_BPW-1:0] outData [DPR_NPORT];
    logic [DPR_BPW-1:0] next_outData [DPR_NPORT];
    logic [DPR_BPW-1:0] memArray [DPR_WORDS];
    logic writeEn [DPR_NPORT];
    logic [DPR_AW-1:0] writeAddr [DPR_NPORT];
    logic [DPR_BPW-1:0] writeWord [DPR_NPORT];
    logic driveEn [DPR_NPORT];

    // Address field of a bundled sample
    function automatic logic [DPR_AW-1:0] addrOf(input logic [DPR_PW-1:0] s);
        addrOf = s[DPR_F_ADDR +: DPR_AW];
    endfunction

    // Data field of a bundled sample
    function automatic logic [DPR_BPW-1:0] dataOf(
        input logic [DPR_PW-1:0] s);
        dataOf = s[DPR_F_DATA +: DPR_BPW];
    endfunction

    assign pinSample[0] = {port_a_clock, port_a_select_n, port_a_write_n,
        port_a_out_enable_n, port_a_addr, port_a_write_data};
    assign pinSample[1] = {port_b_clock, port_b_select_n, port_b_write_n,
        port_b_out_enable_n, port_b_addr, port_b_write_data};

    always_comb begin
        for (int p = 0; p < DPR_NPORT; p++) begin
            next_syncStage[p][0] = pinSample[p];
            next_syncStage[p][1] = syncStage[p][0];
            next_syncStage[p][2] = syncStage[p][1];
            // A bit changes once the second and third stage agree
            for (int b = 0; b < DPR_PW; b++) begin
                if (syncStage[p][1][b] == syncStage[p][2][b]) begin
                    next_level[p][b] = syncStage[p][2][b];
                end else begin
                    next_level[p][b] = level[p][b];
                end
            end
        end
    end

    always_comb begin
        for (int p = 0; p < DPR_NPORT; p++) begin
            writeEn[p] = 1'b0;
            writeAddr[p] = addrOf(next_level[p]);
            writeWord[p] = dataOf(next_level[p]);
            next_outData[p] = outData[p];
            // access only at the filtered rising edge
            // select gates the edge; standby otherwise
            if (next_level[p][DPR_F_CLK] && !level[p][DPR_F_CLK]
                    && !next_level[p][DPR_F_SELN]) begin
                if (next_level[p][DPR_F_WRN]) begin
                    next_outData[p] = memArray[addrOf(next_level[p])];
                end else begin
                    writeEn[p] = 1'b1;
                    // written word also shown on output
                    next_outData[p] = dataOf(next_level[p]);
                end
            end
            // drive only while clock high, selected, enabled
            driveEn[p] = level[p][DPR_F_CLK] && !level[p][DPR_F_SELN]
                && !level[p][DPR_F_OEN];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int p = 0; p < DPR_NPORT; p++) begin
                for (int s = 0; s < DPR_SYNC; s++) begin
                    syncStage[p][s] <= '0;
                end
                level[p] <= '0;
                outData[p] <= DPR_DATA_RESET;
            end
        end else begin
            syncStage <= next_syncStage;
            level <= next_level;
            outData <= next_outData;
        end
    end

    // Storage has no reset; port B is written last on a same-word clash
    always_ff @(posedge clk_sys) begin
        for (int p = 0; p < DPR_NPORT; p++) begin
            if (writeEn[p]) begin
                memArray[writeAddr[p]] <= writeWord[p];
            end
        end
    end

    assign port_a_read_data = outData[0];
    assign port_b_read_data = outData[1];
    assign port_a_read_data_oe = driveEn[0];
    assign port_b_read_data_oe = driveEn[1];
endmodule // dpr_dual_port_ram
`default_nettype wire

// [bench/dpr_ram_checker.sv]
// Port timing checks for the dual-port RAM.
// Bound to the RAM top; pins move clear of clk_sys edges.
`timescale 1ns/1ps
`default_nettype none
module dpr_ram_checker import dpr_pkg::*; (
    input wire logic clk_sys, reset_n, port_a_clock, port_b_clock,
    input wire logic port_a_select_n, port_a_write_n, port_a_out_enable_n,
    input wire logic port_b_select_n, port_b_write_n, port_b_out_enable_n,
    input wire logic port_a_read_data_oe, port_b_read_data_oe,
    input wire logic [DPR_BPW-1:0] port_a_write_data, port_a_read_data,
    input wire logic [DPR_BPW-1:0] port_b_write_data, port_b_read_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_aon; $rose(port_a_clock) && !port_a_select_n
        && !port_a_out_enable_n |-> ##4 port_a_read_data_oe; endproperty
    a_aon: assert property (p_aon) else $error("a drive");
    property p_aoff; $fell(port_a_clock) |-> ##4 !port_a_read_data_oe;
    endproperty
    a_aoff: assert property (p_aoff) else $error("a release");
    property p_aecho; $rose(port_a_clock) && !port_a_select_n
        && !port_a_write_n |-> ##4 port_a_read_data ==
        $past(port_a_write_data, 4); endproperty
    a_aecho: assert property (p_aecho) else $error("a echo");
    property p_aidle; $rose(port_a_clock) && port_a_select_n |-> ##1
        ($stable(port_a_read_data) && !port_a_read_data_oe)[*6]; endproperty
    a_aidle: assert property (p_aidle) else $error("a idle");
    property p_bon; $rose(port_b_clock) && !port_b_select_n
        && !port_b_out_enable_n |-> ##4 port_b_read_data_oe; endproperty
    a_bon: assert property (p_bon) else $error("b drive");
    property p_boff; $fell(port_b_clock) |-> ##4 !port_b_read_data_oe;
    endproperty
    a_boff: assert property (p_boff) else $error("b release");
    property p_becho; $rose(port_b_clock) && !port_b_select_n
        && !port_b_write_n |-> ##4 port_b_read_data ==
        $past(port_b_write_data, 4); endproperty
    a_becho: assert property (p_becho) else $error("b echo");
    property p_bidle; $rose(port_b_clock) && port_b_select_n |-> ##1
        ($stable(port_b_read_data) && !port_b_read_data_oe)[*6]; endproperty
    a_bidle: assert property (p_bidle) else $error("b idle");
    c_awr: cover property ($rose(port_a_clock) && !port_a_write_n);
    c_bsel: cover property ($rose(port_b_clock) && port_b_select_n);
    c_both: cover property (port_a_read_data_oe && port_b_read_data_oe);
endmodule // dpr_ram_checker
bind dpr_dual_port_ram dpr_ram_checker i_chk(.*);
`default_nettype wire

// [bench/dpr_port_model.sv]
// Surrounding logic that drives one RAM port.
// Pins move 5 ns after clk_sys; the caller picks the access.
`timescale 1ns/1ps
`default_nettype none
module dpr_port_model import dpr_pkg::*; (
    input wire logic clk_sys, // System clock
    input wire logic [DPR_BPW-1:0] rData, // Port output word
    input wire logic rOe, // Port output driving
    output logic pClk, selN, wrN, oeN, // Port clock and controls
    output logic [DPR_AW-1:0] addr, // Port address
    output logic [DPR_BPW-1:0] wData // Port write word
);
    initial {pClk, selN, wrN, oeN, addr, wData} = {4'h7, 24'h0};
    task automatic access(input logic s, w, o, input logic [DPR_AW-1:0] a,
        input logic [DPR_BPW-1:0] d, output logic [DPR_BPW-1:0] q,
        output logic qOe);
        @(posedge clk_sys);
        #5 {selN, wrN, oeN, addr, wData} = {s, w, o, a, d};
        repeat (4) @(posedge clk_sys);
        #5 pClk = 1;
        repeat (7) @(posedge clk_sys);
        // output taken only while clock high
        #5;
        {q, qOe} = {rData, rOe};
        pClk = 0;
        repeat (6) @(posedge clk_sys);
        #5 {addr, wData} = {~a, ~d};
    endtask
endmodule // dpr_port_model
`default_nettype wire

// [bench/testbench.sv]
// Random and corner accesses on both RAM ports, checked against a copy.
// Runs the RAM top with its bound checker and one port model on each side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dpr_pkg::*;
    logic clk_sys = 0, reset_n = 0;
    logic port_a_clock, port_a_select_n, port_a_write_n, port_a_out_enable_n;
    logic port_b_clock, port_b_select_n, port_b_write_n, port_b_out_enable_n;
    logic port_a_read_data_oe, port_b_read_data_oe;
    logic [DPR_AW-1:0] port_a_addr, port_b_addr;
    logic [DPR_BPW-1:0] port_a_write_data, port_a_read_data, mem [DPR_WORDS];
    logic [DPR_BPW-1:0] port_b_write_data, port_b_read_data;
    int n_errors = 0, comparisons = 0, seed = 32'h5ea6;
    logic [31:0] ra, rb;
    always #50 clk_sys = ~clk_sys;
    dpr_dual_port_ram i_dut(.*);
    dpr_port_model i_pa(.clk_sys, .rData(port_a_read_data),
        .rOe(port_a_read_data_oe), .pClk(port_a_clock), .selN(port_a_select_n),
        .wrN(port_a_write_n), .oeN(port_a_out_enable_n), .addr(port_a_addr),
        .wData(port_a_write_data));
    dpr_port_model i_pb(.clk_sys, .rData(port_b_read_data),
        .rOe(port_b_read_data_oe), .pClk(port_b_clock), .selN(port_b_select_n),
        .wrN(port_b_write_n), .oeN(port_b_out_enable_n), .addr(port_b_addr),
        .wData(port_b_write_data));
    function automatic logic [DPR_BPW-1:0] exp_word(logic w,
        logic [DPR_AW-1:0] a, logic [DPR_BPW-1:0] d);
        return w ? mem[a] : d;
    endfunction
    task automatic check(string n, logic [DPR_BPW-1:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(bit p, logic s, w, o, logic [DPR_AW-1:0] a,
        logic [DPR_BPW-1:0] d);
        logic [DPR_BPW-1:0] q;
        logic qOe;
        if (p) i_pb.access(s, w, o, a, d, q, qOe);
        else i_pa.access(s, w, o, a, d, q, qOe);
        check("drive", {15'h0, !s && !o}, {15'h0, qOe});
        if (!s && !o) check("word", exp_word(w, a, d), q);
        if (!s && !w) mem[a] = d;
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        #5 reset_n = 1;
        for (int i = 0; i < 80; i++) begin
            ra = $random(seed);
            rb = $random(seed);
            // disjoint halves while both ports run
            fork
                acc(0, &ra[1:0], ra[2], &ra[4:3], {4'h0, ra[11:8]}, ra[31:16]);
                acc(1, &rb[1:0], rb[2], &rb[4:3], {4'h8, rb[11:8]}, rb[31:16]);
            join
        end
        acc(0, 0, 0, 0, 8'h05, 16'hA5A5);
        acc(1, 0, 1, 0, 8'h05, 16'h0000);
        acc(1, 1, 0, 0, 8'h05, 16'h5A5A);
        acc(0, 0, 1, 0, 8'h05, 16'h0000);
        acc(0, 0, 1, 1, 8'h05, 16'h0000);
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
